/* sequencer_defines.svh */
/*
 Constants for the LED driver protection sequencer: register byte
 offsets, reset values, event bit positions and sequencing counts.
 Assumes it is included by bare name from the package and the design.
*/
`ifndef SEQUENCER_DEFINES_SVH
`define SEQUENCER_DEFINES_SVH
// ============================================================
// Register byte offsets
`define OFF_CTRL       8'h00
`define OFF_ONTIME     8'h04
`define OFF_MINPER     8'h08
`define OFF_THERM      8'h0C
`define OFF_SHUT       8'h10
`define OFF_STATUS     8'h14
`define OFF_ISTAT      8'h18
`define OFF_IMASK      8'h1C
// ============================================================
// Reset values
`define RST_ENABLE     1'b1
`define RST_ONTIME     16'h0100
`define RST_MINPER     16'h0400
`define RST_THR_HI     10'h0320
`define RST_THR_LO     10'h0190
`define RST_THR_SH     10'h0064
`define RST_SCALE      7'h64
// ============================================================
// Event bit positions in status and mask
`define EV_LINE_OVP    0
`define EV_OUT_OVP     1
`define EV_OCP         2
`define EV_SHORT       3
`define EV_THERM_SHUT  4
`define EV_INACTIVE    5
// ============================================================
// Sequencing counts
`define SOFT_MIN_WIDTH 16'h0008
`define SOFT_STEP      16'h0004
`define LINE_OVP_HALFS 4'h0F
`define OUT_OVP_CYCLES 2'h2
`define RETRY_LIMIT    2'h3
`define WAKE_REQUESTS  5'h1D
`define THERM_HYST_MV  11'h0054
`define THERM_STEPS    3'h4
`endif

/* sequencer_pkg.sv */
/*
 Types of the LED driver protection sequencer: sequencer states and the
 packed state record. Assumes the defines header is on the include path.
*/
`include "sequencer_defines.svh"
package sequencer_pkg;
   // ============================================================
   // Sequencer states
   typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_RUN, ST_FAULT,
                             ST_INACTIVE, ST_SHUTDOWN} state_type;
   // ============================================================
   // Whole state of the sequencer
   typedef struct packed {
      state_type   st;
      logic        gate;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        irq;
      logic        enable;
      logic [15:0] ontime;
      logic [15:0] min_period;
      logic [15:0] width;
      logic [15:0] per_cnt;
      logic [15:0] on_cnt;
      logic [9:0]  thr_hi;
      logic [9:0]  thr_lo;
      logic [9:0]  thr_sh;
      logic        aux_prev;
      logic        valley_prev;
      logic        cross_prev;
      logic        supply_prev;
      logic        aux_fell;
      logic        aux_over;
      logic        line_seen;
      logic [3:0]  lovp_cnt;
      logic [1:0]  oovp_cnt;
      logic [1:0]  retry;
      logic [4:0]  wake_cnt;
      logic [2:0]  tlevel;
      logic [6:0]  scale;
      logic [5:0]  ist;
      logic [5:0]  imask;
   } seq_state_type;
endpackage

/* input_sync.sv */
/*
 Two flip-flop synchroniser for a group of comparator levels.
 Assumes each bit is a slow level; multi-bit codes must be held stable.
*/
`timescale 1ns/100ps
`default_nettype none
module input_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q; // First stage, read by second stage only

   // ============================================================
   // Two stage capture
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= '0;
         dout   <= '0;
      end
      else
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule // input_sync
`default_nettype wire

/* led_driver_protection_sequencer.sv */
/*
 LED driver switching and protection sequencer with an APB register port.
 Assumes comparator levels from the analogue front end, a thermistor code
 in millivolts, and an APB master on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sequencer_defines.svh"
module led_driver_protection_sequencer
   import sequencer_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic        pready,
   output var  logic [31:0] prdata,
   output var  logic        pslverr,
   input  wire logic        aux_high,
   input  wire logic        valley_detect,
   input  wire logic        aux_over_max,
   input  wire logic        line_above_ovp,
   input  wire logic        line_cross,
   input  wire logic        overcurrent_trip,
   input  wire logic        peak_current_limit,
   input  wire logic        sense_short_detect,
   input  wire logic        supply_good,
   input  wire logic        supply_discharged,
   input  wire logic [9:0]  thermistor_mv,
   output var  logic        gate_drive,
   output var  logic [6:0]  current_scale,
   output var  logic        irq
);
   seq_state_type s_q;       // Registered state
   seq_state_type s_d;       // Next state
   logic [19:0]   sync_out;  // Synchronised comparator group
   logic [9:0]    vt;        // Thermistor code
   logic aux_s, valley_s, aover_s, lhigh_s, cross_s;
   logic ocp_s, pcl_s, short_s, sup_s, dis_s;
   logic aux_fall, valley_rise, cross_rise, power_req;
   logic turn_on, shut_now, complete;

   // ============================================================
   // Synchronisers for every pin level
   input_sync #(.WIDTH(20)) u_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({thermistor_mv, aux_high, valley_detect, aux_over_max,
                 line_above_ovp, line_cross, overcurrent_trip,
                 peak_current_limit, sense_short_detect, supply_good,
                 supply_discharged}),
      .dout    (sync_out)
   );
   assign {vt, aux_s, valley_s, aover_s, lhigh_s, cross_s, ocp_s, pcl_s,
           short_s, sup_s, dis_s} = sync_out;

   // ============================================================
   // Functions
   // Step threshold k counts down from the upper limit
   function automatic logic [10:0] step_thr(input logic [9:0] hi,
                                            input logic [9:0] lo,
                                            input logic [2:0] k);
      logic [10:0] span;
      logic [10:0] prod;
      span = (hi > lo) ? {1'b0, hi - lo} : 11'h000;
      prod = 11'((span >> 2) * 11'(k - 3'h1));
      return {1'b0, hi} - prod;
   endfunction

   // Output current percentage per step
   function automatic logic [6:0] scale_of(input logic [2:0] lvl);
      case (lvl)
         3'h0:    return 7'h64;
         3'h1:    return 7'h4B;
         3'h2:    return 7'h32;
         3'h3:    return 7'h19;
         default: return 7'h01;
      endcase
   endfunction

   // ============================================================
   // Edge detectors on synchronised levels
   assign aux_fall    = s_q.aux_prev & ~aux_s;
   assign valley_rise = valley_s & ~s_q.valley_prev;
   assign cross_rise  = cross_s & ~s_q.cross_prev;
   assign power_req   = sup_s & ~s_q.supply_prev;
   assign shut_now    = ({1'b0, vt} < {1'b0, s_q.thr_sh});
   assign complete    = psel & penable & s_q.pready;
   // Turn-on needs valley, aux edge and the minimum period
   assign turn_on = (s_q.st == ST_SOFT || s_q.st == ST_RUN) && !s_q.gate &&
                    s_q.enable && valley_rise &&
                    (s_q.aux_fell || aux_fall) &&
                    (s_q.per_cnt >= s_q.min_period);

   // ============================================================
   // Next state
   always_comb
   begin
      logic [5:0] ev;
      logic       fault;
      ev    = 6'h00;
      fault = 1'b0;
      s_d   = s_q;
      s_d.aux_prev    = aux_s;
      s_d.valley_prev = valley_s;
      s_d.cross_prev  = cross_s;
      s_d.supply_prev = sup_s;
      s_d.pready      = 1'b0;
      s_d.per_cnt     = (s_q.per_cnt == 16'hFFFF) ? s_q.per_cnt : s_q.per_cnt + 16'h0001;

      // APB: answer one cycle into the access phase
      if (psel && penable && !s_q.pready)
      begin
         s_d.pready  = 1'b1;
         s_d.pslverr = 1'b0;
         s_d.prdata  = 32'h0000_0000;
         case (paddr)
            `OFF_CTRL:   s_d.prdata = {31'h0000_0000, s_q.enable};
            `OFF_ONTIME: s_d.prdata = {16'h0000, s_q.ontime};
            `OFF_MINPER: s_d.prdata = {16'h0000, s_q.min_period};
            `OFF_THERM:  s_d.prdata = {6'h00, s_q.thr_lo, 6'h00, s_q.thr_hi};
            `OFF_SHUT:   s_d.prdata = {22'h00_0000, s_q.thr_sh};
            `OFF_STATUS: s_d.prdata = {16'h0000, 2'h0, s_q.tlevel, s_q.wake_cnt,
                                       s_q.retry, s_q.gate, s_q.st};
            `OFF_ISTAT:  s_d.prdata = {26'h000_0000, s_q.ist};
            `OFF_IMASK:  s_d.prdata = {26'h000_0000, s_q.imask};
            default:     s_d.pslverr = 1'b1; // Unmapped answers with error
         endcase
      end
      // Writes land on the completing edge only
      if (complete && pwrite)
      begin
         case (paddr)
            `OFF_CTRL:   s_d.enable     = pwdata[0];
            `OFF_ONTIME: s_d.ontime     = pwdata[15:0];
            `OFF_MINPER: s_d.min_period = pwdata[15:0];
            `OFF_THERM:
            begin
               s_d.thr_hi = pwdata[9:0];
               s_d.thr_lo = pwdata[25:16];
            end
            `OFF_SHUT:   s_d.thr_sh     = pwdata[9:0];
            `OFF_IMASK:  s_d.imask      = pwdata[5:0];
            default:     s_d.enable     = s_q.enable;
         endcase
      end

      // Thermal steps, one step per clock, with hysteresis
      if (s_q.tlevel < `THERM_STEPS &&
          {1'b0, vt} <= step_thr(s_q.thr_hi, s_q.thr_lo, s_q.tlevel + 3'h1))
         s_d.tlevel = s_q.tlevel + 3'h1;
      else if (s_q.tlevel != 3'h0 &&
               {1'b0, vt} > step_thr(s_q.thr_hi, s_q.thr_lo, s_q.tlevel) +
                            `THERM_HYST_MV)
         s_d.tlevel = s_q.tlevel - 3'h1;
      s_d.scale = scale_of(s_d.tlevel);

      // Switching cycle bookkeeping
      if (aux_fall)
         s_d.aux_fell = 1'b1;
      if (aover_s && !s_q.gate)
         s_d.aux_over = 1'b1;
      if (lhigh_s)
         s_d.line_seen = 1'b1;
      if (s_q.gate)
      begin
         s_d.on_cnt = s_q.on_cnt + 16'h0001;
         if (ocp_s || pcl_s || s_q.on_cnt + 16'h0001 >= s_q.width)
         begin
            s_d.gate = 1'b0;
            if (ocp_s)
               ev[`EV_OCP] = 1'b1;
            // Widen the next soft-start pulse
            if (s_q.st == ST_SOFT)
               s_d.width = s_q.width + `SOFT_STEP;
         end
      end
      if (turn_on)
      begin
         s_d.gate     = 1'b1;
         s_d.per_cnt  = 16'h0000;
         s_d.on_cnt   = 16'h0000;
         s_d.aux_fell = 1'b0;
         s_d.aux_over = 1'b0;
         // Aux overvoltage judged once per switching cycle
         if (s_q.aux_over)
         begin
            s_d.oovp_cnt = s_q.oovp_cnt + 2'h1;
            if (s_d.oovp_cnt == `OUT_OVP_CYCLES)
            begin
               fault = 1'b1;
               ev[`EV_OUT_OVP] = 1'b1;
            end
         end
         else
            s_d.oovp_cnt = 2'h0;
      end
      // Line overvoltage judged once per half line cycle
      if (cross_rise)
      begin
         s_d.line_seen = lhigh_s;
         if (s_q.line_seen && (s_q.st == ST_SOFT || s_q.st == ST_RUN))
         begin
            s_d.lovp_cnt = s_q.lovp_cnt + 4'h1;
            if (s_d.lovp_cnt == `LINE_OVP_HALFS)
            begin
               fault = 1'b1;
               ev[`EV_LINE_OVP] = 1'b1;
            end
         end
         else
            s_d.lovp_cnt = 4'h0;
      end
      if (s_q.st == ST_RUN && short_s)
      begin
         fault = 1'b1;
         ev[`EV_SHORT] = 1'b1;
      end

      // Sequencer
      case (s_q.st)
         ST_OFF:
         begin
            s_d.gate = 1'b0;
            if (power_req && s_q.retry == `RETRY_LIMIT)
            begin
               s_d.st       = ST_INACTIVE;
               s_d.wake_cnt = 5'h00;
               ev[`EV_INACTIVE] = 1'b1;
            end
            else if (power_req)
            begin
               s_d.st    = ST_SOFT;
               s_d.width = `SOFT_MIN_WIDTH;
               // A fresh start has no earlier pulse to demagnetise
               s_d.aux_fell = 1'b1;
            end
         end
         ST_SOFT, ST_RUN:
         begin
            if (s_q.st == ST_SOFT && s_d.width >= s_q.ontime)
            begin
               s_d.st    = ST_RUN;
               s_d.width = s_q.ontime;
            end
            if (fault)
            begin
               s_d.st    = ST_FAULT;
               s_d.gate  = 1'b0;
               s_d.retry = (s_q.retry == `RETRY_LIMIT) ? s_q.retry :
                           s_q.retry + 2'h1;
            end
            else if (shut_now)
            begin
               s_d.st   = ST_SHUTDOWN;
               s_d.gate = 1'b0;
               ev[`EV_THERM_SHUT] = 1'b1;
            end
         end
         ST_SHUTDOWN:
         begin
            s_d.gate = 1'b0;
            if (!shut_now)
            begin
               s_d.st    = ST_SOFT;
               s_d.aux_fell = 1'b1;
               s_d.width = `SOFT_MIN_WIDTH;
            end
         end
         ST_FAULT:
            s_d.gate = 1'b0; // Stays biased until undervoltage
         ST_INACTIVE:
         begin
            s_d.gate = 1'b0;
            // Power-on requests are counted, not answered
            if (power_req)
            begin
               s_d.wake_cnt = s_q.wake_cnt + 5'h01;
               if (s_d.wake_cnt == `WAKE_REQUESTS)
               begin
                  s_d.st    = ST_SOFT;
                  s_d.aux_fell = 1'b1;
                  s_d.retry = 2'h0;
                  s_d.width = `SOFT_MIN_WIDTH;
               end
            end
         end
         default:
            s_d.st = ST_OFF;
      endcase
      // Undervoltage drops any active state back to off
      if (!sup_s && s_q.st != ST_INACTIVE && s_q.st != ST_OFF)
      begin
         s_d.st   = ST_OFF;
         s_d.gate = 1'b0;
      end
      // A fully discharged supply forgets all retry history
      if (dis_s)
      begin
         s_d.st       = ST_OFF;
         s_d.gate     = 1'b0;
         s_d.retry    = 2'h0;
         s_d.wake_cnt = 5'h00;
      end
      if (s_d.st != ST_SOFT && s_d.st != ST_RUN)
      begin
         s_d.lovp_cnt = 4'h0;
         s_d.oovp_cnt = 2'h0;
      end

      // Sticky events: a read clears, a new event wins
      if (complete && !pwrite && paddr == `OFF_ISTAT)
         s_d.ist = ev;
      else
         s_d.ist = s_q.ist | ev;
      s_d.irq = |(s_d.ist & s_d.imask);
   end

   // ============================================================
   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q            <= '0;
         s_q.st         <= ST_OFF;
         s_q.enable     <= `RST_ENABLE;
         s_q.ontime     <= `RST_ONTIME;
         s_q.min_period <= `RST_MINPER;
         s_q.width      <= `SOFT_MIN_WIDTH;
         s_q.thr_hi     <= `RST_THR_HI;
         s_q.thr_lo     <= `RST_THR_LO;
         s_q.thr_sh     <= `RST_THR_SH;
         s_q.scale      <= `RST_SCALE;
      end
      else
         s_q <= s_d;
   end

   assign pready        = s_q.pready;
   assign prdata        = s_q.prdata;
   assign pslverr       = s_q.pslverr;
   assign gate_drive    = s_q.gate;
   assign current_scale = s_q.scale;
   assign irq           = s_q.irq;

   // ============================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence seq_two_over;
      turn_on && s_q.aux_over && s_q.oovp_cnt == 2'h1;
   endsequence
   sequence seq_inactive_req;
      s_q.st == ST_INACTIVE && power_req && s_q.wake_cnt == 5'h1C && !dis_s;
   endsequence

   a_valley_turn_on: assert property ($rose(gate_drive) |-> $past(valley_rise))
      else $error("gate rose without a valley");
   a_min_period_held: assert property ($rose(gate_drive) |->
      $past(s_q.per_cnt) >= $past(s_q.min_period))
      else $error("gate rose before minimum period");
   a_aux_edge_seen: assert property ($rose(gate_drive) |->
      $past(s_q.aux_fell || aux_fall))
      else $error("gate rose without aux falling edge");
   a_line_ovp_trip: assert property (cross_rise && s_q.line_seen && s_q.lovp_cnt == 4'hE
      && s_q.st == ST_RUN && sup_s && !dis_s |=> s_q.st == ST_FAULT)
      else $error("line overvoltage not declared");
   a_out_ovp_trip: assert property (seq_two_over and
      (s_q.st inside {ST_SOFT, ST_RUN} && sup_s && !dis_s)
      |=> s_q.st == ST_FAULT ##1 !gate_drive)
      else $error("output overvoltage not declared");
   a_fault_gate_off: assert property (s_q.st == ST_FAULT |-> !gate_drive)
      else $error("gate on during fault");
   a_retry_inactive: assert property (s_q.st == ST_OFF && power_req && s_q.retry == 2'h3
      && !dis_s |=> s_q.st == ST_INACTIVE && s_q.ist[`EV_INACTIVE])
      else $error("inactive not entered");
   a_wake_count: assert property (seq_inactive_req |=>
      s_q.st == ST_SOFT && s_q.retry == 2'h0)
      else $error("inactive did not wake");
   a_discharge_clear: assert property (dis_s |=> s_q.retry == 2'h0 && s_q.st == ST_OFF)
      else $error("discharge did not clear");
   a_ocp_cut: assert property (gate_drive && ocp_s |=> !gate_drive)
      else $error("gate stayed on after overcurrent");
   a_short_fault: assert property (s_q.st == ST_RUN && short_s && sup_s && !dis_s
      |=> s_q.st == ST_FAULT)
      else $error("sense short not handled");
   a_shutdown_off: assert property (shut_now && s_q.st == ST_RUN |=> !gate_drive)
      else $error("gate on in thermal shutdown");
endmodule // led_driver_protection_sequencer
`default_nettype wire

/* power_stage_model.sv */
/*
 Far-side model: power switch, aux winding and sense comparators.
 Assumes one pclk domain and the gate level from the sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
module power_stage_model
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic gate_drive,
   input  wire logic ovp_force,
   input  wire logic oc_force,
   output var  logic aux_high,
   output var  logic valley_detect,
   output var  logic aux_over_max,
   output var  logic overcurrent_trip,
   output var  logic peak_current_limit
);
   // ============================================================
   // Counters of the switching cycle
   logic [15:0] off_cnt;   // Cycles since the gate fell
   logic [3:0]  on_cnt;    // Cycles with the gate high
   // Both counters saturate so a long idle cannot wrap them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         off_cnt <= 16'h0000;
         on_cnt  <= 4'h0;
      end
      else if (gate_drive)
      begin
         off_cnt <= 16'h0000;
         on_cnt  <= on_cnt + {3'h0, on_cnt != 4'hF};
      end
      else
      begin
         off_cnt <= off_cnt + {15'h0000, off_cnt != 16'hFFFF};
         on_cnt  <= 4'h0;
      end
   end
   // Demagnetising pulse, then a ringing valley every 16 cycles
   assign aux_high = !gate_drive && off_cnt >= 16'h0001 && off_cnt < 16'h0007;
   assign valley_detect = !gate_drive && off_cnt >= 16'h0010 && off_cnt[3:1] == 3'h7;
   // Over-voltage is only visible while the aux winding conducts
   assign aux_over_max = ovp_force && aux_high;
   // Peak current crosses the trip point on the fourth on cycle
   assign overcurrent_trip = oc_force && gate_drive && on_cnt >= 4'h3;
   assign peak_current_limit = 1'b0;
endmodule // power_stage_model
`default_nettype wire

/* test_led_driver_protection_sequencer.sv */
/*
 Self-checking bench of the protection sequencer with a power stage model.
 Assumes the sequencer package and defines header are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sequencer_defines.svh"
module test_led_driver_protection_sequencer
   import sequencer_pkg::*;
;
   // ============================================================
   // Bench signals
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic        aux_high, valley_detect, aux_over_max, overcurrent_trip;
   logic        peak_current_limit, line_above_ovp, line_cross, supply_good;
   logic        supply_discharged, sense_short_detect, gate_drive, irq;
   logic        ovp_force, oc_force, gate_q, aux_q, aux_fell;
   logic [7:0]  paddr, vhist;
   logic [31:0] pwdata, prdata, rdv;
   logic [9:0]  thermistor_mv;
   logic [6:0]  current_scale;
   logic [15:0] minper, ontime;
   int          error_cnt, check_count, gap, wid, oc_len, gcnt, g0;
   int          wq[$];   // Widths of the gate pulses seen
   // Reset values of the register map, read in a loop
   logic [7:0]  ra[6] = '{`OFF_CTRL, `OFF_ONTIME, `OFF_MINPER, `OFF_THERM,
                          `OFF_SHUT, `OFF_IMASK};
   logic [31:0] rv[6] = '{{31'h0, `RST_ENABLE}, {16'h0000, `RST_ONTIME},
                          {16'h0000, `RST_MINPER}, {6'h00, `RST_THR_LO, 6'h00,
                          `RST_THR_HI}, {22'h00_0000, `RST_THR_SH}, 32'h0000_0000};
   // Thermistor walk down then back up, with the expected percent
   logic [9:0]  tv[6] = '{10'h320, 10'h2BC, 10'h258, 10'h190, 10'h352, 10'h384};
   logic [6:0]  ts[6] = '{7'h4B, 7'h32, 7'h19, 7'h01, 7'h4B, 7'h64};

   led_driver_protection_sequencer i_led_driver_protection_sequencer (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .aux_high,
      .valley_detect, .aux_over_max, .line_above_ovp, .line_cross, .overcurrent_trip,
      .peak_current_limit, .sense_short_detect, .supply_good, .supply_discharged,
      .thermistor_mv, .gate_drive, .current_scale, .irq);
   power_stage_model i_power_stage_model (.pclk, .presetn, .gate_drive, .ovp_force,
      .oc_force, .aux_high, .valley_detect, .aux_over_max, .overcurrent_trip,
      .peak_current_limit);

   always #4 pclk = ~pclk;

   // ============================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer; starts and ends just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Poll the state field, then compare it
   task automatic st(input logic [2:0] e, input int tries);
      int n;
      n = 0;
      do
         apb(1'b0, `OFF_STATUS, 32'h0000_0000);
      while (rdv[2:0] !== e && n++ < tries);
      chk({29'h0, rdv[2:0]}, {29'h0, e});
   endtask
   // Supply dips then comes back: one power-on request
   task automatic req;
      supply_good <= 1'b0;
      cyc(8);
      supply_good <= 1'b1;
      cyc(8);
   endtask
   // One half line cycle; the level is high only mid-cycle if asked
   task automatic half(input logic x);
      line_cross <= 1'b1;
      cyc(5);
      line_above_ovp <= x;
      cyc(5);
      line_above_ovp <= 1'b0;
      cyc(5);
      line_cross <= 1'b0;
      cyc(10);
   endtask
   task automatic finish_test;
      $display("Checks %0d, errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ============================================================
   // Gate monitor: valley, aux edge, period, width, overcurrent
   always @(posedge pclk)
   begin
      vhist <= {vhist[6:0], valley_detect};
      gate_q <= gate_drive;
      aux_q <= aux_high;
      gap <= (gate_drive && !gate_q) ? 1 : gap + 1;
      wid <= gate_drive ? wid + 1 : 0;
      oc_len <= (overcurrent_trip && gate_drive) ? oc_len + 1 : 0;
      if (aux_q && !aux_high)
         aux_fell <= 1'b1;
      if (gate_q && !gate_drive)
         wq.push_back(wid);
      if (gate_drive && !gate_q)
      begin
         gcnt <= gcnt + 1;
         chk({31'h0, |(vhist[6:1] & ~vhist[7:2])}, 32'h1);
         chk({31'h0, aux_fell}, 32'h1);
         chk({31'h0, gap >= minper}, 32'h1);
         aux_fell <= 1'b0;
      end
      if (oc_len > 4)
         chk(oc_len, 0);
   end

   // Watchdog sized well above the whole sequence
   initial
   begin
      cyc(60000);
      error_cnt++;
      finish_test();
   end

   // ============================================================
   // Main sequence
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {line_above_ovp, line_cross, supply_good, supply_discharged} = '0;
      {sense_short_detect, ovp_force, oc_force, gate_q, aux_q, aux_fell} = '0;
      {vhist, gap, wid, oc_len, gcnt, error_cnt, check_count} = '0;
      thermistor_mv = 10'h3E8;
      void'($urandom(18));
      minper = 16'h0040 + 16'($urandom % 64);
      ontime = 16'h0010 + 16'($urandom % 16);
      cyc(8);
      presetn <= 1'b1;
      cyc(1);
      foreach (ra[i])
      begin
         apb(1'b0, ra[i], 32'h0000_0000);
         chk(rdv, rv[i]);
      end
      // Unmapped offset is refused both ways
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({rdv[30:0], rerr}, 32'h1);
      apb(1'b1, `OFF_ONTIME, {16'h0000, ontime});
      apb(1'b1, `OFF_MINPER, {16'h0000, minper});
      // Power-on: soft start widens pulses, then run
      req();
      st(ST_RUN, 400);
      chk(wq[0], 8);
      chk(wq[1], 12);
      // Overcurrent with the interrupt masked, then unmasked
      g0 = gcnt;
      oc_force <= 1'b1;
      cyc(600);
      chk({31'h0, gcnt - g0 >= 2}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      oc_force <= 1'b0;
      cyc(10);
      apb(1'b1, `OFF_IMASK, 32'h0000_003F);
      cyc(3);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, `OFF_ISTAT, 32'h0000_0000);
      chk({31'h0, rdv[`EV_OCP]}, 32'h1);
      cyc(3);
      chk({31'h0, irq}, 32'h0);
      st(ST_RUN, 0);
      // Line over-voltage: a break restarts the count
      repeat (10) half(1'b1);
      half(1'b0);
      repeat (15) half(1'b1);
      st(ST_RUN, 0);
      half(1'b0);
      st(ST_FAULT, 3);
      chk({30'h0, irq, gate_drive}, 32'h2);
      apb(1'b0, `OFF_ISTAT, 32'h0000_0000);
      chk({31'h0, rdv[`EV_LINE_OVP]}, 32'h1);
      supply_good <= 1'b0;
      st(ST_OFF, 3);
      // Output over-voltage faults until the block goes inactive
      repeat (2)
      begin
         req();
         ovp_force <= 1'b1;
         st(ST_FAULT, 300);
         ovp_force <= 1'b0;
      end
      apb(1'b0, `OFF_ISTAT, 32'h0000_0000);
      chk({31'h0, rdv[`EV_OUT_OVP]}, 32'h1);
      req();
      st(ST_INACTIVE, 3);
      repeat (28) req();
      st(ST_INACTIVE, 0);
      req();
      st(ST_SOFT, 3);
      chk({30'h0, rdv[5:4]}, 32'h0);
      ovp_force <= 1'b1;
      st(ST_FAULT, 300);
      ovp_force <= 1'b0;
      req();
      // Thermal steps down and back up, then shutdown
      foreach (tv[i])
      begin
         thermistor_mv <= tv[i];
         cyc(20);
         chk({25'h0, current_scale}, {25'h0, ts[i]});
      end
      thermistor_mv <= 10'h032;
      st(ST_SHUTDOWN, 5);
      thermistor_mv <= 10'h3E8;
      // Full discharge clears retry, wake and state
      supply_good <= 1'b0;
      supply_discharged <= 1'b1;
      st(ST_OFF, 5);
      chk({25'h0, rdv[10:4]}, 32'h0);
      supply_discharged <= 1'b0;
      // Shorted sense resistor while running
      req();
      st(ST_RUN, 400);
      sense_short_detect <= 1'b1;
      st(ST_FAULT, 3);
      apb(1'b0, `OFF_ISTAT, 32'h0000_0000);
      chk({31'h0, rdv[`EV_SHORT]}, 32'h1);
      finish_test();
   end
endmodule // test_led_driver_protection_sequencer
`default_nettype wire
